// File: rtl/pc_sequencer.sv
// Program counter sequencer with upper latch, paging and return stack
// Behaviour
// - 13-bit counter, low byte read/write
// - Upper bits hidden, written via latch
// - Any reset clears upper counter bits
// - Low byte write loads latch bits 4:0
// - Call/jump take top bits from latch
// - Call/jump supply low 11 bits
// - Eight-entry 13-bit stack, pointer hidden
// - Push on call and interrupt vector
// - Pop on the single return operation
// - Push and pop leave latch alone
// - Stack wraps circularly after eight pushes
// - No overflow or underflow status
// - Returns restore all 13 bits
// - 8K space in four 2K pages
module pc_sequencer
(
	input  wire logic                            i_clk,
	input  wire logic                            i_rst_n,
	input  wire pc_seq_pkg::pc_op_e              i_op,
	input  wire logic [pc_seq_pkg::LOW_W-1:0]    i_low_data,
	input  wire logic [pc_seq_pkg::BRANCH_W-1:0] i_branch_addr,
	input  wire logic                            i_latch_we,
	input  wire logic [pc_seq_pkg::LATCH_W-1:0]  i_latch_data,
	output logic      [pc_seq_pkg::PC_W-1:0]     o_pc,
	output logic      [pc_seq_pkg::LOW_W-1:0]    o_pc_low_byte,
	output logic      [pc_seq_pkg::LATCH_W-1:0]  o_pc_upper_latch
);
	import pc_seq_pkg::*;

	// Counter and upper latch state
	logic [PC_W-1:0]          pc_reg;
	logic [PC_W-1:0]          pc_next;
	logic [LATCH_W-1:0]       latch_reg;
	logic [LATCH_W-1:0]       latch_next;

	// Operation decode
	logic                     op_hold;
	logic                     op_incr;
	logic                     op_write_low;
	logic                     op_jump;
	logic                     op_call;
	logic                     op_return;
	logic                     op_int;
	logic                     op_branch;

	// Candidate next counter values
	logic [PC_W-1:0]          seq_addr;
	logic [PC_W-1:0]          low_write_addr;
	logic [PC_W-1:0]          branch_target;
	logic [PC_W-1:0]          return_addr;
	logic [PC_W-1:0]          stack_top;
	logic [HIGH_W-1:0]        high_from_latch;
	logic [PC_W-BRANCH_W-1:0] page_from_latch;

	// Stack controls
	logic                     push;
	logic                     pop;

	// One-hot decode keeps the next-value mux shallow
	always_comb
	begin
		op_hold      = 1'b0;
		op_incr      = 1'b0;
		op_write_low = 1'b0;
		op_jump      = 1'b0;
		op_call      = 1'b0;
		op_return    = 1'b0;
		op_int       = 1'b0;
		case (i_op)
			OP_NONE:
			begin
				op_hold = 1'b1;
			end

			OP_INCR:
			begin
				op_incr = 1'b1;
			end

			OP_WRITE_LOW:
			begin
				op_write_low = 1'b1;
			end

			OP_JUMP:
			begin
				op_jump = 1'b1;
			end

			OP_CALL:
			begin
				op_call = 1'b1;
			end

			OP_RETURN:
			begin
				op_return = 1'b1;
			end

			OP_INT:
			begin
				op_int = 1'b1;
			end

			default:
			begin
				// Undefined codes hold rather than jump wild
				op_hold = 1'b1;
			end
		endcase
	end

	// Call and jump share one address path
	assign op_branch = op_jump || op_call;

	// Plain fetch advance, wraps at the top of the space
	assign seq_addr = pc_reg + PC_ONE;
	// Interrupt pushes the address it would have resumed at
	assign return_addr = pc_reg + PC_ONE;

	// Old latch value used even if written in the same cycle
	assign high_from_latch = latch_reg[HIGH_W-1:0];
	assign page_from_latch = latch_reg[PAGE_SEL_HI:PAGE_SEL_LO];
	assign low_write_addr  = {high_from_latch, i_low_data};
	assign branch_target   = {page_from_latch, i_branch_addr};

	// Stack never touches the latch
	assign push = op_call || op_int;
	assign pop  = op_return;

	// Hidden pointer, no status back to the core
	return_stack
	#(
		.DEPTH (STACK_DEPTH),
		.PTR_W (STACK_PTR_W),
		.W     (PC_W)
	)
	u_stack
	(
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_push  (push),
		.i_pop   (pop),
		.i_data  (return_addr),
		.o_top   (stack_top)
	);

	// Latch only moves on its own write, never on stack ops
	always_comb
	begin
		latch_next = latch_reg;
		if (i_latch_we)
		begin
			latch_next = i_latch_data;
		end
	end

	// Counter next value
	always_comb
	begin
		pc_next = pc_reg;
		if (op_incr)
		begin
			pc_next = seq_addr;
		end
		else if (op_write_low)
		begin
			pc_next = low_write_addr;
		end
		else if (op_branch)
		begin
			// Page from latch, in-page address from opcode
			pc_next = branch_target;
		end
		else if (op_return)
		begin
			pc_next = stack_top;
		end
		else if (op_int)
		begin
			pc_next = INT_VECTOR;
		end
		else
		begin
			// Hold on idle cycles
			pc_next = pc_reg;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			pc_reg <= PC_RESET;
		end
		else
		begin
			pc_reg <= pc_next;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			latch_reg <= LATCH_RESET;
		end
		else
		begin
			latch_reg <= latch_next;
		end
	end

	// All outputs straight from registers
	assign o_pc             = pc_reg;
	assign o_pc_low_byte    = pc_reg[LOW_W-1:0];
	assign o_pc_upper_latch = latch_reg;
endmodule

// File: rtl/pc_seq_pkg.sv
// Constants for the program counter sequencer and its return stack
package pc_seq_pkg;
	localparam int PC_W        = 13;
	localparam int LOW_W       = 8;
	localparam int HIGH_W      = 5;
	localparam int LATCH_W     = 8;
	localparam int BRANCH_W    = 11;
	localparam int PAGE_SEL_LO = 3;
	localparam int PAGE_SEL_HI = 4;
	localparam int STACK_DEPTH = 8;
	localparam int STACK_PTR_W = 3;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] PC_ONE   = 13'h0001;
	localparam logic [LATCH_W-1:0] LATCH_RESET = 8'h00;
	localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_INCR,
		OP_WRITE_LOW,
		OP_JUMP,
		OP_CALL,
		OP_RETURN,
		OP_INT
	} pc_op_e;
endpackage

// File: rtl/return_stack.sv
// Circular return-address stack with a hidden pointer
module return_stack
#(
	parameter int DEPTH = pc_seq_pkg::STACK_DEPTH,
	parameter int PTR_W = pc_seq_pkg::STACK_PTR_W,
	parameter int W     = pc_seq_pkg::PC_W
)
(
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_push,
	input  wire logic         i_pop,
	input  wire logic [W-1:0] i_data,
	output logic      [W-1:0] o_top
);
	import pc_seq_pkg::*;

	logic [W-1:0]     mem_reg [DEPTH];
	logic [W-1:0]     mem_next [DEPTH];
	logic [PTR_W-1:0] ptr_reg;
	logic [PTR_W-1:0] ptr_next;

	// No flags: overflow and underflow just wrap
	always_comb
	begin
		mem_next = mem_reg;
		ptr_next = ptr_reg;
		if (i_push)
		begin
			mem_next[ptr_reg] = i_data;
			ptr_next = ptr_reg + PTR_W'(1);
		end
		else if (i_pop)
		begin
			ptr_next = ptr_reg - PTR_W'(1);
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			ptr_reg <= '0;
		else
			ptr_reg <= ptr_next;
		mem_reg <= mem_next;
	end

	// Entry one below the pointer is the most recent push
	assign o_top = mem_reg[ptr_reg - PTR_W'(1)];
endmodule

// File: bench/pc_seq_sva.sv
// Port assertions for the program counter sequencer
module pc_seq_sva
import pc_seq_pkg::*;
(
	input wire logic        i_clk, i_rst_n, i_latch_we,
	input wire pc_op_e      i_op,
	input wire logic [7:0]  i_low_data, i_latch_data,
	input wire logic [7:0]  o_pc_low_byte, o_pc_upper_latch,
	input wire logic [10:0] i_branch_addr,
	input wire logic [12:0] o_pc
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_call_ret;
		i_op == OP_CALL ##1 i_op == OP_RETURN;
	endsequence
	AST_INCR: assert property (i_op == OP_INCR |=>
		o_pc == 13'($past(o_pc) + 1))
		else $error("increment wrong");
	AST_WLOW: assert property (i_op == OP_WRITE_LOW |=>
		o_pc == {$past(o_pc_upper_latch[4:0]), $past(i_low_data)})
		else $error("low byte load wrong");
	AST_BR: assert property (i_op inside {OP_JUMP, OP_CALL} |=>
		o_pc == {$past(o_pc_upper_latch[4:3]), $past(i_branch_addr)})
		else $error("branch load wrong");
	AST_INT: assert property (i_op == OP_INT |=> o_pc == INT_VECTOR)
		else $error("vector wrong");
	AST_LAT: assert property (!i_latch_we |=> $stable(o_pc_upper_latch))
		else $error("latch moved");
	AST_LOW: assert property (o_pc_low_byte == o_pc[7:0])
		else $error("low byte mismatch");
	AST_RET: assert property (s_call_ret |=>
		o_pc == 13'($past(o_pc, 2) + 1))
		else $error("return address wrong");
	AST_RST: assert property (disable iff (1'b0) !i_rst_n |=> o_pc == PC_RESET)
		else $error("reset value wrong");
endmodule
bind pc_sequencer pc_seq_sva u_pc_seq_sva(.*);

// File: bench/core_model.sv
// Decoder model issuing one operation per cycle
module core_model
import pc_seq_pkg::*;
(
	input  wire logic   i_clk,
	output pc_op_e      o_op = OP_NONE,
	output logic [10:0] o_addr = '0,
	output logic        o_we = 1'b0,
	output logic [7:0]  o_lat = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	// Low byte writes double as computed jumps
	task automatic issue(pc_op_e op, logic [10:0] a = '0, logic w = 0,
		logic [7:0] d = 8'h00);
		@(posedge i_clk);
		#1;
		{o_op, o_addr, o_we, o_lat} = {op, a, w, d};
	endtask
endmodule

// File: bench/tb_pc_sequencer.sv
// Self-checking bench for the program counter sequencer
module tb_pc_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	import pc_seq_pkg::*;
	logic i_clk = 0, i_rst_n = 0, we;
	pc_op_e op;
	logic [10:0] a;
	logic [7:0] lat, lb, ul;
	logic [12:0] pc, p;
	int errors = 0, n_checks = 0, cyc = 0;
	initial forever #25 i_clk = ~i_clk;
	core_model u_core_model(.i_clk, .o_op(op), .o_addr(a), .o_we(we),
		.o_lat(lat));
	pc_sequencer u_pc_sequencer(.i_clk, .i_rst_n, .i_op(op),
		.i_low_data(a[7:0]), .i_branch_addr(a), .i_latch_we(we),
		.i_latch_data(lat), .o_pc(pc), .o_pc_low_byte(lb),
		.o_pc_upper_latch(ul));
	task automatic check(string n, logic [12:0] s, e);
		n_checks++;
		if (s !== e)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic t_page();
		u_core_model.issue(OP_NONE, 0, 1, 8'h1F);
		u_core_model.issue(OP_WRITE_LOW, 11'h0FF, 1, 8'h18);
		u_core_model.issue(OP_INCR);
		check("pc", pc, 13'h1FFF);
		check("low", 13'(lb), 13'h00FF);
		u_core_model.issue(OP_JUMP, 11'h123);
		check("pc", pc, 13'h0000);
		u_core_model.issue(OP_NONE);
		check("pc", pc, 13'h1923);
		$display("page test done");
	endtask
	task automatic t_stack();
		for (int i = 1; i <= 9; i++) u_core_model.issue(OP_CALL, 11'(i));
		u_core_model.issue(OP_RETURN);
		for (int k = 1; k <= 9; k++)
		begin
			u_core_model.issue(k < 9 ? OP_RETURN : OP_NONE);
			check("pop", pc, k < 9 ? 13'(6154 - k) : 13'h1809);
		end
		check("latch", 13'(ul), 13'h0018);
		$display("stack test done");
	endtask
	task automatic t_int();
		p = pc;
		u_core_model.issue(OP_INT);
		u_core_model.issue(OP_RETURN);
		check("vector", pc, INT_VECTOR);
		u_core_model.issue(OP_NONE);
		check("ret", pc, p + 1);
		i_rst_n = 0;
		u_core_model.issue(OP_NONE);
		i_rst_n = 1;
		check("rst", pc | 13'(ul), PC_RESET);
		u_core_model.issue(OP_JUMP, 11'h7FF);
		u_core_model.issue(OP_NONE);
		check("page0", pc, 13'h07FF);
		$display("interrupt test done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge i_clk)
		if (++cyc > 500)
		begin
			errors++;
			tally_and_finish();
		end
	initial
	begin
		repeat (4) @(posedge i_clk);
		#1 i_rst_n = 1;
		t_page();
		t_stack();
		t_int();
		tally_and_finish();
	end
endmodule
